/* design/vrs_sequencer.sv */
// Start-up, shut-down, output reset and sync sequencing for the converter core
`timescale 1ns/100ps
module vrs_sequencer #(
  parameter int unsigned CYC_PER_MS = vrs_pkg::CYC_PER_MS
) (
  // Clock and power-up reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Shared sync/reset pin, as a level and as a clock
  input wire logic sync_reset_pin_i,
  input wire logic sync_clk_i,
  // Strap and control pins
  input wire logic vset_used_i,
  input wire logic [15:0] vset_code_i,
  input wire logic [3:0] ss_bin_i,
  input wire logic enable_pin_i,
  // Digitised feedback, same clock
  input wire logic [15:0] fb_level_i,
  // Command port
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [15:0] cmd_data_i,
  output logic [15:0] rd_data_o,
  output logic rd_valid_o,
  // Converter controls
  output logic [15:0] vref_o,
  output logic hs_en_o,
  output logic ls_en_o,
  output logic sw_tick_o,
  output logic sync_locked_o,
  output logic temp_sense_sel_o
);
  localparam int LAG_A = vrs_pkg::RST_LAG_CYC;
  vrs_pkg::vrs_state_t state_q;
  vrs_pkg::vrs_state_t state_d;
  logic [22:0] pins_s1_q;
  logic [22:0] pins_s2_q;
  logic pin_s;
  logic vused_s;
  logic en_s;
  logic [3:0] ss_s;
  logic [15:0] vset_s;
  logic [1:0] boot_cnt_q;
  logic boot_done_q;
  logic boot_take;
  logic [15:0] boot_vout;
  logic [15:0] default_q;
  logic [15:0] vout_cmd_q;
  logic [7:0] status_q;
  logic [15:0] options_q;
  logic [15:0] misc_q;
  logic [7:0] op_q;
  logic [15:0] trate_q;
  logic [1:0] scale_q;
  logic [6:0] ton_q;
  logic [6:0] toff_q;
  logic sync_mode;
  logic reset_act;
  logic on_req;
  logic hard_off;
  logic [15:0] target;
  logic [6:0] rise_ms;
  logic [6:0] fall_ms;
  logic [24:0] rise_total;
  logic [24:0] fall_total;
  logic [24:0] acc_q;
  logic [24:0] acc_sum;
  logic [15:0] vref_q;
  logic [15:0] fall_start_q;
  logic [15:0] slew_cnt_q;
  logic tog;
  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_s3_q;
  logic sync_edge;
  logic [11:0] per_cnt_q;
  logic [11:0] meas_q;
  logic lock_q;
  logic [11:0] period;
  logic [11:0] sw_cnt_q;
  logic sw_wrap;
  logic started_q;
  logic [7:0] pulse_cnt_q;
  logic [19:0] ls_prod;
  logic drive;
  logic above_fb;
  logic hs_en_q;
  logic ls_en_q;
  logic sw_tick_q;
  logic [15:0] rd_data_q;
  logic rd_valid_q;
  logic wr_vout;

  // Link-domain edge marker
  vrs_sync_toggle u_sync (
    .sync_clk_i(sync_clk_i),
    .rst_i(rst_i),
    .toggle_o(tog)
  );

  // Pin synchronisers
  always_ff @(posedge clock_i) begin
    pins_s1_q <= {sync_reset_pin_i, vset_used_i, enable_pin_i, ss_bin_i, vset_code_i};
    pins_s2_q <= pins_s1_q;
  end
  assign {pin_s, vused_s, en_s, ss_s, vset_s} = pins_s2_q;

  // Boot capture once the strap synchronisers have filled
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      boot_cnt_q <= 2'h0;
      boot_done_q <= 1'b0;
    end else begin
      if (boot_cnt_q != 2'h3) begin
        boot_cnt_q <= boot_cnt_q + 2'h1;
      end
      if (boot_take) begin
        boot_done_q <= 1'b1;
      end
    end
  end
  assign boot_take = (boot_cnt_q == 2'h3) && !boot_done_q;
  assign boot_vout = vused_s ? vset_s : vrs_pkg::VOUT_STORED;

  // Shared pin role and derived requests
  assign sync_mode = !vused_s || misc_q[vrs_pkg::MISC_FORCE_SYNC];
  assign reset_act = !sync_mode && !pin_s;
  assign on_req = boot_done_q && en_s && op_q[vrs_pkg::OP_ON_BIT];
  assign hard_off = !on_req && misc_q[vrs_pkg::MISC_SOFTSTOP_DIS] && (state_q != vrs_pkg::ST_OFF);
  assign wr_vout = cmd_wr_i && (cmd_code_i == vrs_pkg::CMD_VOUT);
  assign temp_sense_sel_o = options_q[vrs_pkg::OPT_SOFTSTART_DETECT_DISABLE];

  // Default output command, latched once after power-up
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      default_q <= 16'h0000;
    end else if (boot_take) begin
      default_q <= boot_vout;
    end
  end

  // Output command: boot default, pin reset, then bus writes
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      vout_cmd_q <= 16'h0000;
    end else if (boot_take) begin
      vout_cmd_q <= boot_vout;
    end else if (reset_act) begin
      vout_cmd_q <= default_q;
    end else if (wr_vout) begin
      vout_cmd_q <= cmd_data_i;
    end
  end

  // Rise time: decoded at boot, replaced by later bus writes
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ton_q <= vrs_pkg::SS_DEFAULT_MS;
    end else if (boot_take && !options_q[vrs_pkg::OPT_SOFTSTART_DETECT_DISABLE]) begin
      ton_q <= vrs_pkg::vrs_ss_ms(ss_s);
    end else if (cmd_wr_i && cmd_code_i == vrs_pkg::CMD_TON_RISE) begin
      if (cmd_data_i == 16'h0000) begin
        ton_q <= 7'h01;
      end else if (cmd_data_i > 16'(vrs_pkg::RISE_MAX_MS)) begin
        ton_q <= vrs_pkg::RISE_MAX_MS;
      end else begin
        ton_q <= cmd_data_i[6:0];
      end
    end
  end

  // Status flags: boot sets, write of ones clears, set wins
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      status_q <= 8'h00;
    end else begin
      status_q <= (status_q & ~((cmd_wr_i && cmd_code_i == vrs_pkg::REG_STATUS) ?
                   cmd_data_i[7:0] : 8'h00))
                  | {6'h00, boot_take && !vused_s,
                     boot_take && !options_q[vrs_pkg::OPT_SOFTSTART_DETECT_DISABLE] &&
                     vrs_pkg::vrs_ss_bad(ss_s)};
    end
  end

  // Plain configuration registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      options_q <= 16'h0000;
      misc_q <= 16'h0000;
      op_q <= vrs_pkg::OP_RESET;
      trate_q <= vrs_pkg::TRATE_RESET;
      scale_q <= 2'h0;
      toff_q <= 7'h00;
    end else if (cmd_wr_i) begin
      case (cmd_code_i)
        vrs_pkg::REG_OPTIONS: options_q <= cmd_data_i;
        vrs_pkg::REG_MISC: misc_q <= cmd_data_i;
        vrs_pkg::CMD_OPERATION: op_q <= cmd_data_i[7:0];
        vrs_pkg::CMD_TRATE: trate_q <= cmd_data_i;
        vrs_pkg::CMD_SCALE: scale_q <= (cmd_data_i[1:0] == 2'h3) ? 2'h2 : cmd_data_i[1:0];
        vrs_pkg::CMD_TOFF_FALL: toff_q <= cmd_data_i[6:0];
        default: ;
      endcase
    end
  end

  // Ramp parameters
  assign target = vout_cmd_q >> scale_q;
  assign rise_ms = (ton_q == 7'h00) ? 7'h01 :
                   (ton_q > vrs_pkg::RISE_MAX_MS) ? vrs_pkg::RISE_MAX_MS : ton_q;
  assign fall_ms = (toff_q == 7'h00) ? vrs_pkg::FALL_MIN_MS : toff_q;
  assign rise_total = 25'(rise_ms) * 25'(CYC_PER_MS);
  assign fall_total = 25'(fall_ms) * 25'(CYC_PER_MS);
  assign acc_sum = acc_q + ((state_q == vrs_pkg::ST_FALL) ? 25'(fall_start_q) : 25'(target));

  // Sequencer state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      vrs_pkg::ST_OFF: if (on_req) state_d = vrs_pkg::ST_RISE;
      vrs_pkg::ST_RISE: begin
        if (hard_off) begin
          state_d = vrs_pkg::ST_OFF;
        end else if (!on_req) begin
          state_d = vrs_pkg::ST_FALL;
        end else if (vref_q >= target) begin
          state_d = vrs_pkg::ST_ON;
        end
      end
      vrs_pkg::ST_ON: begin
        if (hard_off) begin
          state_d = vrs_pkg::ST_OFF;
        end else if (!on_req) begin
          state_d = vrs_pkg::ST_FALL;
        end
      end
      vrs_pkg::ST_FALL: begin
        if (hard_off || vref_q == 16'h0000) begin
          state_d = vrs_pkg::ST_OFF;
        end else if (on_req) begin
          state_d = vrs_pkg::ST_RISE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_q <= vrs_pkg::ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Reference ramps: rate-accumulator up and down, slew in regulation
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      vref_q <= 16'h0000;
      acc_q <= 25'h0;
      fall_start_q <= 16'h0000;
      slew_cnt_q <= 16'h0000;
    end else begin
      unique case (state_q)
        vrs_pkg::ST_OFF: begin
          vref_q <= 16'h0000;
          acc_q <= 25'h0;
        end
        vrs_pkg::ST_RISE: begin
          if (vref_q >= target) begin
            vref_q <= target;
          end else if (acc_sum >= rise_total) begin
            vref_q <= vref_q + 16'h0001;
            acc_q <= acc_sum - rise_total;
          end else begin
            acc_q <= acc_sum;
          end
          fall_start_q <= vref_q;
        end
        vrs_pkg::ST_ON: begin
          acc_q <= 25'h0;
          fall_start_q <= vref_q;
          if (vref_q == target) begin
            slew_cnt_q <= trate_q; // Armed so a new target moves at once
          end else if (slew_cnt_q >= trate_q) begin
            slew_cnt_q <= 16'h0000;
            vref_q <= (vref_q < target) ? vref_q + 16'h0001 : vref_q - 16'h0001;
          end else begin
            slew_cnt_q <= slew_cnt_q + 16'h0001;
          end
        end
        vrs_pkg::ST_FALL: begin
          if (vref_q != 16'h0000 && acc_sum >= fall_total) begin
            vref_q <= vref_q - 16'h0001;
            acc_q <= acc_sum - fall_total;
          end else begin
            acc_q <= acc_sum;
          end
        end
      endcase
    end
  end

  // Sync edge detection and period measurement
  always_ff @(posedge clock_i) begin
    tog_s1_q <= tog;
    tog_s2_q <= tog_s1_q;
    tog_s3_q <= tog_s2_q;
  end
  assign sync_edge = tog_s2_q ^ tog_s3_q;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      per_cnt_q <= 12'h000;
      meas_q <= vrs_pkg::SW_PERIOD;
      lock_q <= 1'b0;
    end else if (sync_edge) begin
      per_cnt_q <= 12'h000;
      meas_q <= per_cnt_q + 12'h001;
      lock_q <= (per_cnt_q + 12'h001 >= vrs_pkg::SYNC_MIN) &&
                (per_cnt_q + 12'h001 <= vrs_pkg::SYNC_MAX);
    end else begin
      if (per_cnt_q != 12'hfff) begin
        per_cnt_q <= per_cnt_q + 12'h001;
      end
      if (per_cnt_q > vrs_pkg::SYNC_MAX) begin
        lock_q <= 1'b0;
      end
    end
  end

  // Switching period counter, phase-locked to accepted sync edges
  assign period = (sync_mode && lock_q) ? meas_q : vrs_pkg::SW_PERIOD;
  assign sw_wrap = sw_cnt_q >= period - 12'h001;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sw_cnt_q <= 12'h000;
      sw_tick_q <= 1'b0;
    end else begin
      sw_tick_q <= sw_wrap || (sync_mode && lock_q && sync_edge);
      if (sw_wrap || (sync_mode && lock_q && sync_edge)) begin
        sw_cnt_q <= 12'h000;
      end else begin
        sw_cnt_q <= sw_cnt_q + 12'h001;
      end
    end
  end

  // Pre-bias hold-off and low-side on-time growth
  always_ff @(posedge clock_i) begin
    if (rst_i || state_q == vrs_pkg::ST_OFF) begin
      started_q <= 1'b0;
      pulse_cnt_q <= 8'h00;
    end else begin
      if (state_q == vrs_pkg::ST_RISE && vref_q > fb_level_i) begin
        started_q <= 1'b1;
      end
      if (started_q && sw_tick_q && pulse_cnt_q != vrs_pkg::LS_RAMP_PULSES) begin
        pulse_cnt_q <= pulse_cnt_q + 8'h01;
      end
    end
  end

  assign ls_prod = period * pulse_cnt_q;
  assign drive = started_q && !hard_off && state_q != vrs_pkg::ST_OFF;
  assign above_fb = vref_q > fb_level_i; // Reference above feedback, for the pre-bias check

  // Driver enables
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hs_en_q <= 1'b0;
      ls_en_q <= 1'b0;
    end else begin
      hs_en_q <= drive;
      ls_en_q <= drive && ((pulse_cnt_q == vrs_pkg::LS_RAMP_PULSES) ||
                           (sw_cnt_q < ls_prod[18:7]));
    end
  end

  // Register read-back
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rd_data_q <= 16'h0000;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= cmd_rd_i;
      case (cmd_code_i)
        vrs_pkg::REG_STATUS: rd_data_q <= {8'h00, status_q};
        vrs_pkg::REG_OPTIONS: rd_data_q <= options_q;
        vrs_pkg::REG_MISC: rd_data_q <= misc_q;
        vrs_pkg::CMD_OPERATION: rd_data_q <= {8'h00, op_q};
        vrs_pkg::CMD_VOUT: rd_data_q <= vout_cmd_q;
        vrs_pkg::CMD_TRATE: rd_data_q <= trate_q;
        vrs_pkg::CMD_SCALE: rd_data_q <= {14'h0000, scale_q};
        vrs_pkg::CMD_TON_RISE: rd_data_q <= {9'h000, ton_q};
        vrs_pkg::CMD_TOFF_FALL: rd_data_q <= {9'h000, toff_q};
        default: rd_data_q <= 16'h0000;
      endcase
    end
  end

  assign rd_data_o = rd_data_q;
  assign rd_valid_o = rd_valid_q;
  assign vref_o = vref_q;
  assign hs_en_o = hs_en_q;
  assign ls_en_o = ls_en_q;
  assign sw_tick_o = sw_tick_q;
  assign sync_locked_o = sync_mode && lock_q;

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_reset_restores_cmd: assert property (boot_done_q && reset_act |=> vout_cmd_q == default_q)
    else $error("pin reset did not restore default");
  a_default_held: assert property (boot_done_q |=> $stable(default_q))
    else $error("default changed after boot");
  a_reset_slew_start: assert property ($rose(reset_act) && state_q == vrs_pkg::ST_ON &&
    default_q != vref_q && trate_q < 16'h0010 |-> ##[1:LAG_A] $changed(vref_q))
    else $error("reference did not move after pin reset");
  a_write_blocked: assert property (boot_done_q && reset_act && wr_vout
    |=> vout_cmd_q == $past(default_q))
    else $error("bus write taken during pin reset");
  a_unused_is_sync: assert property (!vused_s |-> !reset_act && sync_mode)
    else $error("unused select did not give sync role");
  a_force_sync_wins: assert property (misc_q[vrs_pkg::MISC_FORCE_SYNC] && !pin_s
    |-> !reset_act)
    else $error("force-sync ignored");
  a_ss_invalid_flag: assert property (boot_take && !options_q[vrs_pkg::OPT_SOFTSTART_DETECT_DISABLE] &&
    vrs_pkg::vrs_ss_bad(ss_s) |=> status_q[vrs_pkg::STS_INVALID_SOFTSTART_FLAG] && ton_q == 7'h05)
    else $error("bad soft-start bin not flagged");
  a_prebias_hold: assert property ($rose(hs_en_q) |-> $past(above_fb, 2))
    else $error("switching before soft-start passed feedback");
  a_ls_full: assert property (started_q && pulse_cnt_q == 8'h80 && !hard_off &&
    state_q != vrs_pkg::ST_OFF |=> ls_en_q)
    else $error("low side not complementary after 128 pulses");
  a_hard_off_now: assert property (hard_off |=> !hs_en_q && !ls_en_q
    && state_q == vrs_pkg::ST_OFF)
    else $error("drivers not dropped on hard off");

  c_rise_done: cover property (state_q == vrs_pkg::ST_RISE ##1 state_q == vrs_pkg::ST_ON);
  c_pin_reset: cover property ($rose(reset_act) && state_q == vrs_pkg::ST_ON);
  c_sync_lock: cover property ($rose(sync_locked_o));
  c_soft_stop: cover property (state_q == vrs_pkg::ST_FALL ##1 state_q == vrs_pkg::ST_OFF);
endmodule

/* pkg/vrs_pkg.sv */
// Constants, register map and decode helpers for the start-up sequencer
// Functional notes
// - Shared pin in reset role and low: output command returns to latched default.
// - Default output command is captured once after power-up and then held.
// - Reference starts moving toward the default within 2 us, at the transition rate.
// - While the reset pin is low, bus writes of the output command are ignored.
// - External sync clock must be within 20 percent; switching locks to it.
// - Voltage-select pin used: shared pin defaults to reset, sync disabled.
// - Force-sync bit set: shared pin is the sync input even with select used.
// - Voltage-select pin unused: shared pin is the sync input regardless.
// - On enable, reference ramps from zero to scaled command within rise time.
// - Rise time is 1 to 100 ms, from bus or from the decoded resistor.
// - Detect-disable 0 decodes the temp/soft-start pin; 1 gives temperature sensing.
// - Bins give 1,2,3,5,7,10,27,52 ms; short or high gives 5 ms and flag.
// - A bus rise-time write after start-up replaces the decoded value.
// - After power loss the decoded rise time replaces any earlier bus value.
// - With pre-bias, no switching until soft-start exceeds feedback.
// - Low-side on-time grows per pulse; complementary after 128 pulses.
// - Fall time sets the soft-stop ramp from regulation down to zero.
// - Fall time of 0 ms acts as the fastest soft-stop, 1 ms.
// - Soft-stop disabled: turning off drops both drivers at once, no ramp.
package vrs_pkg;
  // Register and command codes
  localparam logic [7:0] REG_STATUS = 8'h80;
  localparam logic [7:0] REG_OPTIONS = 8'he5;
  localparam logic [7:0] REG_MISC = 8'hf0;
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_VOUT = 8'h21;
  localparam logic [7:0] CMD_TRATE = 8'h27;
  localparam logic [7:0] CMD_SCALE = 8'h29;
  localparam logic [7:0] CMD_TON_RISE = 8'h61;
  localparam logic [7:0] CMD_TOFF_FALL = 8'h65;
  // Field positions
  localparam int STS_INVALID_SOFTSTART_FLAG = 0;
  localparam int STS_INVALID_DEFAULT_SELECT_FLAG = 1;
  localparam int OPT_SOFTSTART_DETECT_DISABLE = 0;
  localparam int MISC_FORCE_SYNC = 0;
  localparam int MISC_SOFTSTOP_DIS = 1;
  localparam int OP_ON_BIT = 6;
  // Reset values and limits
  localparam logic [7:0] OP_RESET = 8'h40;
  localparam logic [15:0] TRATE_RESET = 16'h0064;
  localparam logic [15:0] VOUT_STORED = 16'h0200;
  localparam logic [6:0] SS_DEFAULT_MS = 7'h05;
  localparam logic [6:0] RISE_MAX_MS = 7'h64;
  localparam logic [6:0] FALL_MIN_MS = 7'h01;
  // Timing
  localparam int CLK_NS = 10;
  localparam int CYC_PER_MS = 1000000 / CLK_NS;
  localparam int RST_LAG_NS = 2000;
  localparam int RST_LAG_CYC = RST_LAG_NS / CLK_NS;
  localparam logic [11:0] SW_PERIOD = 12'h0c8;
  localparam int SYNC_TOL_PCT = 20;
  localparam logic [11:0] SYNC_MIN = 12'(SW_PERIOD * (100 - SYNC_TOL_PCT) / 100);
  localparam logic [11:0] SYNC_MAX = 12'(SW_PERIOD * (100 + SYNC_TOL_PCT) / 100);
  localparam logic [7:0] LS_RAMP_PULSES = 8'h80;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RISE = 2'b01,
    ST_ON = 2'b10,
    ST_FALL = 2'b11
  } vrs_state_t;
  // Soft-start resistor bin to rise time in ms; 0 is short, 15 is pulled high
  function automatic logic [6:0] vrs_ss_ms(input logic [3:0] bin);
    case (bin)
      4'h1: return 7'h01;
      4'h2: return 7'h02;
      4'h3: return 7'h03;
      4'h4: return 7'h05;
      4'h5: return 7'h07;
      4'h6: return 7'h0a;
      4'h7: return 7'h1b;
      4'h8: return 7'h34;
      default: return SS_DEFAULT_MS;
    endcase
  endfunction
  // Bins outside 1..8 are a shorted or floating-high pin
  function automatic logic vrs_ss_bad(input logic [3:0] bin);
    return (bin == 4'h0) || (bin > 4'h8);
  endfunction
endpackage

/* design/vrs_sync_toggle.sv */
// Link-side edge marker running on the external sync clock
`timescale 1ns/100ps
module vrs_sync_toggle (
  // Link clock and core reset
  input wire logic sync_clk_i,
  input wire logic rst_i,
  // Toggles once per rising sync clock edge
  output logic toggle_o
);
  logic rst_s1_q;
  logic rst_s2_q;
  logic toggle_q;

  // Reset brought into the link domain
  always_ff @(posedge sync_clk_i) begin
    rst_s1_q <= rst_i;
    rst_s2_q <= rst_s1_q;
  end

  // One toggle per rising edge, crossed out as a level
  // Branch form settles to a known level even if this clock was idle during reset
  always_ff @(posedge sync_clk_i) begin
    if (rst_s2_q) begin
      toggle_q <= 1'b0;
    end else if (toggle_q) begin
      toggle_q <= 1'b0;
    end else begin
      toggle_q <= 1'b1;
    end
  end

  assign toggle_o = toggle_q;
endmodule

/* verif/vrs_pin_model.sv */
// Behavioural driver standing on the shared sync/reset pin
`timescale 1ns/100ps
module vrs_pin_model (
  // Control from the bench
  input wire logic run_i,
  input wire logic level_i,
  input wire logic [15:0] half_ns_i,
  // Shared pin
  output logic pin_o
);
  // Clock toggles only while running, otherwise the pin rests at the static level
  initial begin
    pin_o = 1'b1;
    #3;
    forever begin
      if (run_i) begin
        pin_o = ~pin_o;
        #(half_ns_i);
      end else begin
        pin_o = level_i;
        #1;
      end
    end
  end
endmodule

/* verif/tb.sv */
// Self-checking bench for the start-up and shut-down sequencer
`timescale 1ns/100ps
module tb;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic pin, run = 1'b0, level = 1'b1;
  logic [15:0] half_ns = 16'h03e8;
  logic vset_used_i = 1'b1, enable_pin_i = 1'b0, cmd_wr_i = 1'b0, cmd_rd_i = 1'b0;
  logic [15:0] vset_code_i = 16'h0300, fb_level_i = 16'h0000, cmd_data_i = 16'h0000;
  logic [15:0] v;
  logic [3:0] ss_bin_i = 4'h1;
  logic [7:0] cmd_code_i = 8'h00;
  logic [15:0] rd_data_o, vref_o;
  logic rd_valid_o, hs_en_o, ls_en_o, sw_tick_o, sync_locked_o, temp_sense_sel_o;
  logic [15:0] exp_q[$];
  logic [15:0] ms_tab[16] = '{16'h0005, 16'h0001, 16'h0002, 16'h0003, 16'h0005, 16'h0007,
    16'h000a, 16'h001b, 16'h0034, 16'h0005, 16'h0005, 16'h0005, 16'h0005, 16'h0005,
    16'h0005, 16'h0005};
  int fail_count = 0, checked = 0, cycles = 0, n;

  // Design and the pin driver on its far side
  vrs_sequencer #(.CYC_PER_MS(1000)) dut (.clock_i(clock_i), .rst_i(rst_i),
    .sync_reset_pin_i(pin), .sync_clk_i(pin), .vset_used_i(vset_used_i),
    .vset_code_i(vset_code_i), .ss_bin_i(ss_bin_i), .enable_pin_i(enable_pin_i),
    .fb_level_i(fb_level_i), .cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i),
    .cmd_code_i(cmd_code_i), .cmd_data_i(cmd_data_i), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .vref_o(vref_o), .hs_en_o(hs_en_o), .ls_en_o(ls_en_o),
    .sw_tick_o(sw_tick_o), .sync_locked_o(sync_locked_o),
    .temp_sense_sel_o(temp_sense_sel_o));
  vrs_pin_model pin_model (.run_i(run), .level_i(level), .half_ns_i(half_ns), .pin_o(pin));

  // Core clock
  initial begin
    forever #5 clock_i = ~clock_i;
  end

  task automatic complete_run;
    if (fail_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(posedge clock_i);
    cmd_wr_i <= 1'b1;
    cmd_code_i <= code;
    cmd_data_i <= data;
    @(posedge clock_i);
    cmd_wr_i <= 1'b0;
  endtask

  // Read request; the expected word waits in the queue for the monitor
  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    exp_q.push_back(exp);
    @(posedge clock_i);
    cmd_rd_i <= 1'b1;
    cmd_code_i <= code;
    @(posedge clock_i);
    cmd_rd_i <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask

  task automatic power_up;
    rst_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clock_i);
  endtask

  // Wait for the reference to reach a value, counting cycles
  task automatic wait_vref(input logic [15:0] target);
    while (vref_o !== target && n < 2000) begin
      @(posedge clock_i);
      n++;
    end
  endtask

  // Monitor pairs each read answer with the oldest expectation
  always @(posedge clock_i) begin
    if (rd_valid_o === 1'b1) begin
      if (exp_q.size() == 0) check("read count", 16'h0000, 16'h0001);
      else check("read data", exp_q.pop_front(), rd_data_o);
    end
  end

  // Hang guard
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    void'($urandom(26));
    vset_code_i <= 16'h0100 + 16'($urandom_range(511));
    // Decoded rise time per bin; a stale bus value is replaced at every boot
    for (int b = 0; b < 16; b++) begin
      ss_bin_i <= 4'(b);
      power_up();
      rd(8'h61, ms_tab[b]);
      rd(8'h80, {15'h0000, (b == 0 || b > 8)});
      wr(8'h61, 16'h0040);
      rd(8'h61, 16'h0040);
    end
    rd(8'h01, 16'h0040);
    rd(8'h27, 16'h0064);
    rd(8'h33, 16'h0000);
    wr(8'h29, 16'h0003);
    rd(8'h29, 16'h0002);
    rd(8'h21, vset_code_i);
    wr(8'h61, 16'h00c8);
    rd(8'h61, 16'h0064);
    wr(8'h61, 16'h0000);
    rd(8'h61, 16'h0001);
    wr(8'he5, 16'h0001);
    repeat (2) @(posedge clock_i);
    check("temp select", 16'h0001, {15'h0000, temp_sense_sel_o});
    wr(8'he5, 16'h0000);
    repeat (2) @(posedge clock_i);
    check("temp select", 16'h0000, {15'h0000, temp_sense_sel_o});
    // Pin in reset role: command restored and bus writes dropped while low
    wr(8'h21, 16'h0280);
    rd(8'h21, 16'h0280);
    level <= 1'b0;
    repeat (4) @(posedge clock_i);
    rd(8'h21, vset_code_i);
    wr(8'h21, 16'h02a0);
    rd(8'h21, vset_code_i);
    level <= 1'b1;
    // Sync role selection and lock window
    run <= 1'b1;
    repeat (1200) @(posedge clock_i);
    check("locked", 16'h0000, {15'h0000, sync_locked_o});
    wr(8'hf0, 16'h0001);
    repeat (1200) @(posedge clock_i);
    check("locked", 16'h0001, {15'h0000, sync_locked_o});
    half_ns <= 16'h0050;
    repeat (1200) @(posedge clock_i);
    check("locked", 16'h0000, {15'h0000, sync_locked_o});
    half_ns <= 16'h03e8;
    vset_used_i <= 1'b0;
    power_up();
    repeat (1200) @(posedge clock_i);
    check("locked", 16'h0001, {15'h0000, sync_locked_o});
    run <= 1'b0;
    vset_used_i <= 1'b1;
    power_up();
    // Soft-start over 1 ms against a pre-biased output
    wr(8'h61, 16'h0001);
    fb_level_i <= vset_code_i >> 1;
    enable_pin_i <= 1'b1;
    n = 0;
    while (hs_en_o !== 1'b1 && n < 2000) begin
      @(posedge clock_i);
      n++;
    end
    check("vref above feedback", 16'h0001, {15'h0000, vref_o > fb_level_i});
    wait_vref(vset_code_i);
    check("rise time", 16'h0001, {15'h0000, n > 950 && n < 1150});
    // Pin reset while regulating moves the reference back promptly
    wr(8'h27, 16'h0001);
    wr(8'h21, vset_code_i + 16'h0040);
    repeat (300) @(posedge clock_i);
    v = vref_o;
    level <= 1'b0;
    repeat (200) @(posedge clock_i);
    check("reset slew", 16'h0001, {15'h0000, vref_o < v});
    level <= 1'b1;
    // Soft-stop with a zero fall time lasts 1 ms
    wr(8'h65, 16'h0000);
    enable_pin_i <= 1'b0;
    n = 0;
    wait_vref(16'h0000);
    check("fall time", 16'h0001, {15'h0000, n > 950 && n < 1150});
    // Restart from ground: one tick per free period, low side complementary after 128
    enable_pin_i <= 1'b1;
    fb_level_i <= 16'h0000;
    repeat (300) @(posedge clock_i);
    check("drive on", 16'h0001, {15'h0000, hs_en_o});
    n = 0;
    repeat (2000) begin
      @(posedge clock_i);
      if (sw_tick_o === 1'b1) n++;
    end
    check("tick count", 16'h000a, 16'(n));
    repeat (24000) @(posedge clock_i);
    check("low side full", 16'h0001, {15'h0000, ls_en_o});
    // Soft-stop disabled drops both drivers at once
    wr(8'hf0, 16'h0002);
    enable_pin_i <= 1'b0;
    repeat (5) @(posedge clock_i);
    check("drivers off", 16'h0000, {14'h0000, hs_en_o, ls_en_o});
    complete_run();
  end
endmodule
